// file: core/lmd_decoder.v
// opcode decoder for logical, rotate, shift and move instructions
`timescale 1ns/1ns
`default_nettype none
`include "lmd_consts.vh"

module lmd_decoder (
  input  wire        ref_clk,         // core clock, 25 MHz
  input  wire        resetn,          // async reset, active low
  input  wire        instr_valid,     // first opcode word present
  input  wire [15:0] instr_word,      // first opcode word
  input  wire        long_addr,       // operand uses long offset/absolute
  output reg         dec_valid_q,     // decode result valid
  output reg         dec_known_q,     // opcode belongs to this group
  output reg  [4:0]  op_class_q,      // operation class code
  output reg  [2:0]  word_count_q,    // instruction length in words
  output reg  [2:0]  cycle_count_q,   // execution cycles
  output reg         src_acc_q,       // source accumulator, 1 = b
  output reg         dst_acc_q,       // destination accumulator, 1 = b
  output reg  [5:0]  shift_q,         // signed shift amount
  output reg  [1:0]  cond_q,          // aux compare condition
  output reg  [2:0]  aux_sel_q,       // aux register select
  output reg  [3:0]  field_x_q,       // first operand field, bits 7:4
  output reg  [3:0]  field_y_q,       // second operand field, bits 3:0
  output reg         smem_q           // carries a single data operand
);

  // combinational decode results
  reg  [4:0] cls_d;       // class of the current word
  reg        src_d;       // source accumulator select
  reg        dst_d;       // destination accumulator select
  reg  [5:0] shift_d;     // decoded shift
  reg  [2:0] words_d;     // length with penalty
  reg  [2:0] cycles_d;    // cycles with penalty
  reg        smem_d;      // single data operand flag

  // split of the opcode into nibbles
  wire [3:0] nib3 = instr_word[15:12];  // top nibble
  wire [3:0] nib2 = instr_word[11:8];   // second nibble
  wire [3:0] nib1 = instr_word[7:4];    // third nibble
  wire [3:0] nib0 = instr_word[3:0];    // bottom nibble
  wire [7:0] upper = instr_word[15:8];  // upper byte

  // base words of a class
  function [2:0] base_words;
    input [4:0] cls;
    begin
      case (cls)
        `LMD_CLS_COMPARE_MEM_IMM,
        `LMD_CLS_OR_IMM,
        `LMD_CLS_OR_IMM16,
        `LMD_CLS_OR_MEM_CONST,
        `LMD_CLS_XOR_IMM,
        `LMD_CLS_XOR_IMM16,
        `LMD_CLS_XOR_MEM_CONST,
        `LMD_CLS_MOVE_TO_IMM_ADDR,
        `LMD_CLS_MOVE_FROM_IMM,
        `LMD_CLS_MOVE_DATA_MAPPED,
        `LMD_CLS_MOVE_MAPPED_DATA,
        `LMD_CLS_MOVE_DATA_PROG,
        `LMD_CLS_MOVE_PROG_DATA: base_words = `LMD_WORDS_2;
        `LMD_CLS_NONE:           base_words = `LMD_RST_COUNT;
        default:                 base_words = `LMD_WORDS_1;
      endcase
    end
  endfunction

  // base cycles of a class
  function [2:0] base_cycles;
    input [4:0] cls;
    begin
      case (cls)
        `LMD_CLS_MOVE_DATA_PROG:  base_cycles = `LMD_CYCLES_4;
        `LMD_CLS_MOVE_PROG_DATA:  base_cycles = `LMD_CYCLES_3;
        `LMD_CLS_PROG_READ_ACC,
        `LMD_CLS_PROG_WRITE_ACC:  base_cycles = `LMD_CYCLES_5;
        `LMD_CLS_NONE:            base_cycles = `LMD_RST_COUNT;
        default: begin
          // other two-word forms in this group spend two cycles
          if (base_words(cls) == `LMD_WORDS_2) begin
            base_cycles = `LMD_CYCLES_2;
          end else begin
            base_cycles = `LMD_CYCLES_1;
          end
        end
      endcase
    end
  endfunction

  // classes whose low byte addresses a single data operand
  function has_smem;
    input [4:0] cls;
    begin
      case (cls)
        `LMD_CLS_COMPARE_MEM_IMM,
        `LMD_CLS_OR_MEM,
        `LMD_CLS_OR_MEM_CONST,
        `LMD_CLS_XOR_MEM,
        `LMD_CLS_XOR_MEM_CONST,
        `LMD_CLS_MOVE_TO_IMM_ADDR,
        `LMD_CLS_MOVE_FROM_IMM,
        `LMD_CLS_MOVE_DATA_PROG,
        `LMD_CLS_MOVE_PROG_DATA,
        `LMD_CLS_PROG_READ_ACC,
        `LMD_CLS_PROG_WRITE_ACC: has_smem = 1'b1;
        default:                 has_smem = 1'b0;
      endcase
    end
  endfunction

  // sign extend a five bit shift field to six bits
  function [5:0] sext_shift;
    input [4:0] f;
    begin
      sext_shift = {f[4], f};
    end
  endfunction

  // opcode pattern match to a class
  always @* begin
    cls_d   = `LMD_CLS_NONE;
    src_d   = 1'b0;
    dst_d   = 1'b0;
    shift_d = 6'h00;
    case (nib3)
      4'h0: begin
        // unused top nibble in this group
        cls_d = `LMD_CLS_NONE;
      end
      4'h1: begin
        // single operand or/xor into accumulator
        if (nib2[3:1] == 3'h5) begin
          cls_d = `LMD_CLS_OR_MEM;
          src_d = nib2[0];
          dst_d = nib2[0];
        end else if (nib2[3:1] == 3'h6) begin
          cls_d = `LMD_CLS_XOR_MEM;
          src_d = nib2[0];
          dst_d = nib2[0];
        end
      end
      4'h6: begin
        // memory forms with a 16-bit second word
        case (nib2)
          4'h0:    cls_d = `LMD_CLS_COMPARE_MEM_IMM;
          4'h9:    cls_d = `LMD_CLS_OR_MEM_CONST;
          4'hA:    cls_d = `LMD_CLS_XOR_MEM_CONST;
          default: cls_d = `LMD_CLS_NONE;
        endcase
      end
      4'h7: begin
        // move family
        case (nib2)
          4'h0:    cls_d = `LMD_CLS_MOVE_FROM_IMM;
          4'h1:    cls_d = `LMD_CLS_MOVE_TO_IMM_ADDR;
          4'h2:    cls_d = `LMD_CLS_MOVE_DATA_MAPPED;
          4'h3:    cls_d = `LMD_CLS_MOVE_MAPPED_DATA;
          4'hC:    cls_d = `LMD_CLS_MOVE_PROG_DATA;
          4'hD:    cls_d = `LMD_CLS_MOVE_DATA_PROG;
          4'hE:    cls_d = `LMD_CLS_PROG_READ_ACC;
          4'hF:    cls_d = `LMD_CLS_PROG_WRITE_ACC;
          default: cls_d = `LMD_CLS_NONE;
        endcase
      end
      4'hE: begin
        // dual operand and mapped register moves
        if (nib2 == 4'h5) begin
          cls_d = `LMD_CLS_MOVE_DATA_DATA;
        end else if (nib2 == 4'h7) begin
          cls_d = `LMD_CLS_MOVE_MAPPED_MAP;
        end
      end
      4'hF: begin
        src_d = instr_word[`LMD_SRC_BIT_HI];
        dst_d = instr_word[`LMD_DST_BIT_HI];
        if (nib2[3:2] == 2'b00) begin
          // accumulator logic with s and d at bits 9 and 8
          if (nib1 == 4'h4) begin
            cls_d   = `LMD_CLS_OR_IMM;
            shift_d = {2'b00, nib0};
          end else if (nib1 == 4'h5) begin
            cls_d   = `LMD_CLS_XOR_IMM;
            shift_d = {2'b00, nib0};
          end else if (nib1 == 4'h6 && nib0 == 4'h4) begin
            cls_d   = `LMD_CLS_OR_IMM16;
            shift_d = `LMD_SHIFT_16;
          end else if (nib1 == 4'h6 && nib0 == 4'h5) begin
            cls_d   = `LMD_CLS_XOR_IMM16;
            shift_d = `LMD_SHIFT_16;
          end else if (nib1[3:1] == 3'h5) begin
            cls_d   = `LMD_CLS_OR_ACC;
            shift_d = sext_shift(instr_word[4:0]);
          end else if (nib1[3:1] == 3'h6) begin
            cls_d   = `LMD_CLS_XOR_ACC;
            shift_d = sext_shift(instr_word[4:0]);
          end else if (nib1[3:1] == 3'h7) begin
            cls_d   = `LMD_CLS_LOGICAL_SHIFT;
            shift_d = sext_shift(instr_word[4:0]);
          end
        end else if (nib2[3:2] == 2'b01) begin
          if (nib1[3:1] == 3'h3) begin
            cls_d   = `LMD_CLS_ARITH_SHIFT;
            shift_d = sext_shift(instr_word[4:0]);
          end else if (nib1 == 4'hA && nib0[3]) begin
            // condition in bits 9:8, no accumulator
            cls_d = `LMD_CLS_COMPARE_AUX_REG;
            src_d = 1'b0;
            dst_d = 1'b0;
          end else if (nib2[1] == 1'b0 && nib1 == 4'h9) begin
            // single accumulator forms, s at bit 8
            src_d = instr_word[`LMD_DST_BIT_HI];
            dst_d = instr_word[`LMD_DST_BIT_HI];
            case (nib0)
              4'h0:    cls_d = `LMD_CLS_ROTATE_RIGHT;
              4'h1:    cls_d = `LMD_CLS_ROTATE_LEFT;
              4'h2:    cls_d = `LMD_CLS_ROTATE_LEFT_TEST;
              4'h4:    cls_d = `LMD_CLS_COND_SHIFT;
              default: cls_d = `LMD_CLS_NONE;
            endcase
          end
        end
        // outside this group the selects are not meaningful
        if (cls_d == `LMD_CLS_NONE) begin
          src_d = 1'b0;
          dst_d = 1'b0;
        end
      end
      default: begin
        cls_d = `LMD_CLS_NONE;
      end
    endcase
  end

  // counts with the long addressing penalty applied
  always @* begin
    smem_d   = has_smem(cls_d);
    words_d  = base_words(cls_d);
    cycles_d = base_cycles(cls_d);
    if (smem_d && long_addr) begin
      words_d  = words_d + `LMD_LONG_ADDR_EXTRA;
      cycles_d = cycles_d + `LMD_LONG_ADDR_EXTRA;
    end
  end

  // result registers, updated once per presented word
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dec_valid_q   <= 1'b0;
      dec_known_q   <= 1'b0;
      op_class_q    <= `LMD_RST_CLASS;
      word_count_q  <= `LMD_RST_COUNT;
      cycle_count_q <= `LMD_RST_COUNT;
      src_acc_q     <= 1'b0;
      dst_acc_q     <= 1'b0;
      shift_q       <= 6'h00;
      cond_q        <= 2'h0;
      aux_sel_q     <= 3'h0;
      field_x_q     <= 4'h0;
      field_y_q     <= 4'h0;
      smem_q        <= 1'b0;
    end else begin
      dec_valid_q <= instr_valid;
      if (instr_valid) begin
        // capture the decode of this word
        dec_known_q   <= (cls_d != `LMD_CLS_NONE);
        op_class_q    <= cls_d;
        word_count_q  <= words_d;
        cycle_count_q <= cycles_d;
        src_acc_q     <= src_d;
        dst_acc_q     <= dst_d;
        shift_q       <= shift_d;
        cond_q        <= instr_word[9:8];
        aux_sel_q     <= instr_word[2:0];
        field_x_q     <= nib1;
        field_y_q     <= nib0;
        smem_q        <= smem_d;
      end
    end
  end

endmodule

`default_nettype wire

// file: core/lmd_consts.vh
// constants for the logic and move opcode decoder
`ifndef LMD_CONSTS_VH
`define LMD_CONSTS_VH

// operation class codes, 5 bits wide
`define LMD_CLS_NONE              5'h00
`define LMD_CLS_COMPARE_MEM_IMM   5'h01
`define LMD_CLS_COMPARE_AUX_REG   5'h02
`define LMD_CLS_OR_MEM            5'h03
`define LMD_CLS_OR_IMM            5'h04
`define LMD_CLS_OR_IMM16          5'h05
`define LMD_CLS_OR_ACC            5'h06
`define LMD_CLS_OR_MEM_CONST      5'h07
`define LMD_CLS_ROTATE_LEFT       5'h08
`define LMD_CLS_ROTATE_LEFT_TEST  5'h09
`define LMD_CLS_ROTATE_RIGHT      5'h0A
`define LMD_CLS_ARITH_SHIFT       5'h0B
`define LMD_CLS_COND_SHIFT        5'h0C
`define LMD_CLS_LOGICAL_SHIFT     5'h0D
`define LMD_CLS_XOR_MEM           5'h0E
`define LMD_CLS_XOR_IMM           5'h0F
`define LMD_CLS_XOR_IMM16         5'h10
`define LMD_CLS_XOR_ACC           5'h11
`define LMD_CLS_XOR_MEM_CONST     5'h12
`define LMD_CLS_MOVE_DATA_DATA    5'h13
`define LMD_CLS_MOVE_TO_IMM_ADDR  5'h14
`define LMD_CLS_MOVE_FROM_IMM     5'h15
`define LMD_CLS_MOVE_DATA_MAPPED  5'h16
`define LMD_CLS_MOVE_MAPPED_DATA  5'h17
`define LMD_CLS_MOVE_DATA_PROG    5'h18
`define LMD_CLS_MOVE_MAPPED_MAP   5'h19
`define LMD_CLS_MOVE_PROG_DATA    5'h1A
`define LMD_CLS_PROG_READ_ACC     5'h1B
`define LMD_CLS_PROG_WRITE_ACC    5'h1C

// base word and cycle counts, operands in dual access ram
`define LMD_WORDS_1               3'h1
`define LMD_WORDS_2               3'h2
`define LMD_CYCLES_1              3'h1
`define LMD_CYCLES_2              3'h2
`define LMD_CYCLES_3              3'h3
`define LMD_CYCLES_4              3'h4
`define LMD_CYCLES_5              3'h5
// extra word and cycle for long offset or absolute addressing
`define LMD_LONG_ADDR_EXTRA       3'h1

// fixed shift of the sixteen bit shift forms
`define LMD_SHIFT_16              6'h10

// field positions inside the opcode word
`define LMD_SRC_BIT_HI            9
`define LMD_DST_BIT_HI            8
`define LMD_SRC_BIT_LO            4

// reset values of the registered outputs
`define LMD_RST_CLASS             5'h00
`define LMD_RST_COUNT             3'h0

`endif

// file: sim/lmd_decoder_props.sv
// assertion checker watching the opcode decoder ports
`timescale 1ns/1ns
`default_nettype none
`include "lmd_consts.vh"

module lmd_decoder_props (
  input wire logic        ref_clk,       // core clock
  input wire logic        resetn,        // async reset, active low
  input wire logic        instr_valid,   // opcode present
  input wire logic [15:0] instr_word,    // opcode word
  input wire logic        long_addr,     // long addressing flag
  input wire logic        dec_valid_q,   // result valid
  input wire logic        dec_known_q,   // opcode in group
  input wire logic [4:0]  op_class_q,    // class code
  input wire logic [2:0]  word_count_q,  // words
  input wire logic [2:0]  cycle_count_q, // cycles
  input wire logic        src_acc_q,     // source acc
  input wire logic        dst_acc_q,     // destination acc
  input wire logic [5:0]  shift_q,       // shift amount
  input wire logic [1:0]  cond_q,        // compare condition
  input wire logic [2:0]  aux_sel_q,     // aux select
  input wire logic [3:0]  field_x_q,     // operand field x
  input wire logic [3:0]  field_y_q,     // operand field y
  input wire logic        smem_q         // single data operand
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_compare_mem_immediate;
    instr_valid && !long_addr && instr_word[15:8] == 8'h60 |=>
      op_class_q == `LMD_CLS_COMPARE_MEM_IMM && word_count_q == 3'h2 && cycle_count_q == 3'h2;
  endproperty
  a_compare_mem_immediate: assert property (p_compare_mem_immediate) else $error("memory compare decode wrong");

  property p_compare_aux_register;
    instr_valid && instr_word[15:10] == 6'h3D && instr_word[7:3] == 5'h15 |=>
      op_class_q == `LMD_CLS_COMPARE_AUX_REG && cycle_count_q == 3'h1
      && aux_sel_q == $past(instr_word[2:0]);
  endproperty
  a_compare_aux_register: assert property (p_compare_aux_register) else $error("aux compare decode wrong");

  property p_or_smem;
    instr_valid && instr_word[15:9] == 7'h0D |=>
      op_class_q == `LMD_CLS_OR_MEM && src_acc_q == $past(instr_word[8]);
  endproperty
  a_or_smem: assert property (p_or_smem) else $error("or operand decode wrong");

  property p_shift16;
    dec_valid_q && op_class_q == `LMD_CLS_OR_IMM16 |->
      shift_q == 6'h10 && dst_acc_q == $past(instr_word[8]);
  endproperty
  a_shift16: assert property (p_shift16) else $error("sixteen shift form wrong");

  property p_move_data_to_data;
    instr_valid && instr_word[15:8] == 8'hE5 |=> op_class_q == `LMD_CLS_MOVE_DATA_DATA
      && word_count_q == 3'h1 && field_x_q == $past(instr_word[7:4]);
  endproperty
  a_move_data_to_data: assert property (p_move_data_to_data) else $error("data move decode wrong");

  property p_move_data_to_program;
    instr_valid && !long_addr && instr_word[15:8] == 8'h7D |=>
      word_count_q == 3'h2 && cycle_count_q == 3'h4;
  endproperty
  a_move_data_to_program: assert property (p_move_data_to_program) else $error("data to program counts wrong");

  property p_move_program_to_data;
    instr_valid && !long_addr && instr_word[15:8] == 8'h7C |=>
      word_count_q == 3'h2 && cycle_count_q == 3'h3;
  endproperty
  a_move_program_to_data: assert property (p_move_program_to_data) else $error("program to data counts wrong");

  property p_prog;
    instr_valid && !long_addr && instr_word[15:9] == 7'h3F |=>
      word_count_q == 3'h1 && cycle_count_q == 3'h5;
  endproperty
  a_prog: assert property (p_prog) else $error("program access counts wrong");

  property p_long;
    instr_valid && long_addr && instr_word[15:8] == 8'h69 ##1 !instr_valid |=>
      word_count_q == 3'h3 && cycle_count_q == 3'h3 && !dec_valid_q;
  endproperty
  a_long: assert property (p_long) else $error("long address penalty wrong");
endmodule

bind lmd_decoder lmd_decoder_props u_props (.ref_clk(ref_clk), .resetn(resetn),
  .instr_valid(instr_valid), .instr_word(instr_word), .long_addr(long_addr),
  .dec_valid_q(dec_valid_q), .dec_known_q(dec_known_q), .op_class_q(op_class_q),
  .word_count_q(word_count_q), .cycle_count_q(cycle_count_q), .src_acc_q(src_acc_q),
  .dst_acc_q(dst_acc_q), .shift_q(shift_q), .cond_q(cond_q), .aux_sel_q(aux_sel_q),
  .field_x_q(field_x_q), .field_y_q(field_y_q), .smem_q(smem_q));
`default_nettype wire

// file: sim/lmd_decoder_tb.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
`include "lmd_consts.vh"

module lmd_decoder_tb;
  logic        ref_clk = 1'b0;   // core clock
  logic        resetn = 1'b0;    // reset, active low
  logic        instr_valid = 1'b0; // opcode present
  logic [15:0] instr_word = 16'h0000; // opcode
  logic        long_addr = 1'b0; // long addressing
  logic        dv, dk, sa, da, sm; // single-bit results
  logic [4:0]  cls;              // class result
  logic [2:0]  wc, cc, ax;       // counts, aux select
  logic [5:0]  sh;               // shift result
  logic [1:0]  cd;               // condition result
  logic [3:0]  fx, fy;           // operand fields
  int          error_cnt = 0;    // mismatches
  int          checks = 0;       // comparisons

  lmd_decoder DUT (.ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .long_addr(long_addr), .dec_valid_q(dv), .dec_known_q(dk),
    .op_class_q(cls), .word_count_q(wc), .cycle_count_q(cc), .src_acc_q(sa),
    .dst_acc_q(da), .shift_q(sh), .cond_q(cd), .aux_sel_q(ax), .field_x_q(fx),
    .field_y_q(fy), .smem_q(sm));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // present one word at a falling edge, judge it one cycle later
  task dec(input logic [15:0] w, input logic l, input logic [4:0] c,
           input logic [2:0] nw, input logic [2:0] nc);
    begin
      instr_valid = 1'b1;
      instr_word = w;
      long_addr = l;
      @(negedge ref_clk);
      checks++;
      if (dv !== 1'b1 || cls !== c || wc !== nw || cc !== nc || dk !== (c != 5'h00)) begin
        error_cnt++;
        $display("[FAIL] %0t word %h gave class %h counts %0d/%0d", $time, w, cls, wc, cc);
      end
    end
  endtask

  // accumulator selects and shift of one word
  task acc(input logic [15:0] w, input logic s, input logic d, input logic [5:0] f);
    begin
      instr_valid = 1'b1;
      instr_word = w;
      long_addr = 1'b0;
      @(negedge ref_clk);
      checks++;
      if (sa !== s || da !== d || sh !== f) begin
        error_cnt++;
        $display("[FAIL] %0t word %h gave selects %b%b shift %h", $time, w, sa, da, sh);
      end
    end
  endtask

  // raw operand fields and single operand flag of one word
  task fld(input logic [15:0] w, input logic [1:0] c, input logic [2:0] a,
           input logic [3:0] x, input logic [3:0] y, input logic s);
    begin
      instr_valid = 1'b1;
      instr_word = w;
      long_addr = 1'b0;
      @(negedge ref_clk);
      checks++;
      if (cd !== c || ax !== a || fx !== x || fy !== y || sm !== s) begin
        error_cnt++;
        $display("[FAIL] %0t word %h gave fields %h %h %h %h %b", $time, w, cd, ax, fx, fy, sm);
      end
    end
  endtask

  // logical, rotate and shift group, back to back
  task t_logic;
    begin
      dec(16'h6012, 1'b0, `LMD_CLS_COMPARE_MEM_IMM, 3'h2, 3'h2);
      dec(16'hF4AB, 1'b0, `LMD_CLS_COMPARE_AUX_REG, 3'h1, 3'h1);
      dec(16'h1A05, 1'b0, `LMD_CLS_OR_MEM, 3'h1, 3'h1);
      dec(16'hF347, 1'b0, `LMD_CLS_OR_IMM, 3'h2, 3'h2);
      dec(16'hF364, 1'b0, `LMD_CLS_OR_IMM16, 3'h2, 3'h2);
      dec(16'hF2A3, 1'b0, `LMD_CLS_OR_ACC, 3'h1, 3'h1);
      dec(16'h6900, 1'b0, `LMD_CLS_OR_MEM_CONST, 3'h2, 3'h2);
      dec(16'hF591, 1'b0, `LMD_CLS_ROTATE_LEFT, 3'h1, 3'h1);
      dec(16'hF592, 1'b0, `LMD_CLS_ROTATE_LEFT_TEST, 3'h1, 3'h1);
      dec(16'hF590, 1'b0, `LMD_CLS_ROTATE_RIGHT, 3'h1, 3'h1);
      dec(16'hF493, 1'b0, `LMD_CLS_NONE, 3'h0, 3'h0);
      dec(16'hF66A, 1'b0, `LMD_CLS_ARITH_SHIFT, 3'h1, 3'h1);
      dec(16'hF594, 1'b0, `LMD_CLS_COND_SHIFT, 3'h1, 3'h1);
      dec(16'hF1EF, 1'b0, `LMD_CLS_LOGICAL_SHIFT, 3'h1, 3'h1);
      dec(16'h1D10, 1'b0, `LMD_CLS_XOR_MEM, 3'h1, 3'h1);
      dec(16'hF056, 1'b0, `LMD_CLS_XOR_IMM, 3'h2, 3'h2);
      dec(16'hF065, 1'b0, `LMD_CLS_XOR_IMM16, 3'h2, 3'h2);
      dec(16'hF3C2, 1'b0, `LMD_CLS_XOR_ACC, 3'h1, 3'h1);
      dec(16'h6A00, 1'b0, `LMD_CLS_XOR_MEM_CONST, 3'h2, 3'h2);
    end
  endtask

  // move group
  task t_move;
    begin
      dec(16'hE512, 1'b0, `LMD_CLS_MOVE_DATA_DATA, 3'h1, 3'h1);
      dec(16'h7100, 1'b0, `LMD_CLS_MOVE_TO_IMM_ADDR, 3'h2, 3'h2);
      dec(16'h7000, 1'b0, `LMD_CLS_MOVE_FROM_IMM, 3'h2, 3'h2);
      dec(16'h7280, 1'b0, `LMD_CLS_MOVE_DATA_MAPPED, 3'h2, 3'h2);
      dec(16'h7300, 1'b0, `LMD_CLS_MOVE_MAPPED_DATA, 3'h2, 3'h2);
      dec(16'h7D00, 1'b0, `LMD_CLS_MOVE_DATA_PROG, 3'h2, 3'h4);
      dec(16'hE734, 1'b0, `LMD_CLS_MOVE_MAPPED_MAP, 3'h1, 3'h1);
      dec(16'h7C00, 1'b0, `LMD_CLS_MOVE_PROG_DATA, 3'h2, 3'h3);
      dec(16'h7E80, 1'b0, `LMD_CLS_PROG_READ_ACC, 3'h1, 3'h5);
      dec(16'h7F00, 1'b0, `LMD_CLS_PROG_WRITE_ACC, 3'h1, 3'h5);
    end
  endtask

  // long addressing adds to single operand forms only
  task t_long;
    begin
      dec(16'h6000, 1'b1, `LMD_CLS_COMPARE_MEM_IMM, 3'h3, 3'h3);
      dec(16'h7D00, 1'b1, `LMD_CLS_MOVE_DATA_PROG, 3'h3, 3'h5);
      dec(16'h7E00, 1'b1, `LMD_CLS_PROG_READ_ACC, 3'h2, 3'h6);
      dec(16'h7200, 1'b1, `LMD_CLS_MOVE_DATA_MAPPED, 3'h2, 3'h2);
      dec(16'hE512, 1'b1, `LMD_CLS_MOVE_DATA_DATA, 3'h1, 3'h1);
      dec(16'h6900, 1'b1, `LMD_CLS_OR_MEM_CONST, 3'h3, 3'h3);
      // one idle cycle, penalised counts must hold
      instr_valid = 1'b0;
      @(negedge ref_clk);
      checks++;
      if (dv !== 1'b0 || wc !== 3'h3 || cc !== 3'h3) begin
        error_cnt++;
        $display("[FAIL] %0t long counts did not hold while idle", $time);
      end
    end
  endtask

  // operand fields, condition, aux select, single operand flag
  task t_fields;
    begin
      fld(16'hF6AD, 2'h2, 3'h5, 4'hA, 4'hD, 1'b0);
      fld(16'hE734, 2'h3, 3'h4, 4'h3, 4'h4, 1'b0);
      fld(16'h7C5A, 2'h0, 3'h2, 4'h5, 4'hA, 1'b1);
      fld(16'h7280, 2'h2, 3'h0, 4'h8, 4'h0, 1'b0);
    end
  endtask

  // accumulator selects and shift fields at their edges
  task t_acc;
    begin
      acc(16'hF364, 1'b1, 1'b1, `LMD_SHIFT_16);
      acc(16'hF245, 1'b1, 1'b0, 6'h05);
      acc(16'hF14F, 1'b0, 1'b1, 6'h0F);
      acc(16'hF2B0, 1'b1, 1'b0, 6'h30);
      acc(16'hF1EF, 1'b0, 1'b1, 6'h0F);
    end
  endtask

  // valid drops, results hold
  task t_idle;
    begin
      instr_valid = 1'b0;
      repeat (2) @(negedge ref_clk);
      checks++;
      if (dv !== 1'b0 || cls !== `LMD_CLS_LOGICAL_SHIFT) begin
        error_cnt++;
        $display("[FAIL] %0t results did not hold while idle", $time);
      end
    end
  endtask

  // verdict and end of run
  task end_of_test;
    begin
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    t_logic;
    t_move;
    t_long;
    t_fields;
    t_acc;
    t_idle;
    end_of_test;
  end

  // watchdog, run needs about 50 cycles
  initial begin
    #(40 * 400);
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
